// ---- fqrc_top.sv ----
`include "fqrc_consts.svh"
// Function
// - A set mask bit hides open-wire and undervoltage faults; voltage still measured.
// - Mask is 14 bits; bit 0 is cell 1 through bit 13 cell 14.
// - Reference good check runs 20 ms after power-up, enable rise or wake.
// - Sleep turns off pass-transistor drive; sleep regulator supplies logic.
// - Enable pin low holds the device in reset; pin has a pull-up.
// - Hard reset command forces enable logic low, same as an external low.
// - Hard reset reinitialises all but the sleep regulators.
// - Hard and soft reset commands return registers to default values.
// - Temperature pull-ups connect only while the bias output is active.
// - Enabled input above 31/32 full scale is open; sets bit and summary.
// - Enabled input below programmed limit is flagged over-temperature.
// - Test enable set checks thresholds; clear leaves plain measurement.
module fqrc_top #(
   parameter logic [19:0] REF_DELAY_CYC = 20'(`FQRC_REF_DELAY_CYC)
) (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               srst,
   // Register port
   input  wire logic [7:0]         regAddr,
   input  wire logic [15:0]        regWrData,
   input  wire logic               regWrEn,
   input  wire logic               regRdEn,
   output logic      [15:0]        regRdData,
   // Pins and analog status
   input  wire logic               enPin,
   input  wire logic               refGoodPin,
   // Link commands and power events
   input  wire logic               hardResetCmd,
   input  wire logic               softResetCmd,
   input  wire logic               wakeDone,
   // Measurement results
   input  wire fqrc_pkg::fqrc_cell_s cellIn,
   input  wire fqrc_pkg::fqrc_temp_s tempIn,
   // Fault outputs
   output logic      [13:0]        cellOpenFault,
   output logic      [13:0]        cellUvFault,
   output logic      [5:0]         overTempFault,
   output logic                    overTempSummaryFlag,
   output logic                    refFault,
   // Power and bias controls
   output logic                    passDriveOn,
   output logic                    sleepRegOn,
   output logic                    tempBiasSwitchOutput,
   output logic      [5:0]         tempPullUpOn,
   output logic                    enLogicLow,
   output logic                    intReq
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and reset generation
   logic       enMeta_ff, enSync_ff, refMeta_ff, refSync_ff;
   logic       nxt_enMeta, nxt_enSync, nxt_refMeta, nxt_refSync;
   logic [4:0] hrstCnt_ff, nxt_hrstCnt;
   logic       enLow_ff, nxt_enLow;
   logic       sleepReg_ff, nxt_sleepReg;
   logic       intRst;
   logic       regRst;

   always_comb begin
      nxt_enMeta  = enPin;
      nxt_enSync  = enMeta_ff;
      nxt_refMeta = refGoodPin;
      nxt_refSync = refMeta_ff;
      nxt_hrstCnt = hrstCnt_ff;
      if (hardResetCmd) begin
         nxt_hrstCnt = `FQRC_HRST_HOLD_CYC;
      end else if (hrstCnt_ff != 5'h00) begin
         nxt_hrstCnt = hrstCnt_ff - 5'h01;
      end
      // Enable logic low from the pin or the command alike
      nxt_enLow    = ~enSync_ff | (nxt_hrstCnt != 5'h00);
      nxt_sleepReg = 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         enMeta_ff   <= 1'b1;
         enSync_ff   <= 1'b1;
         refMeta_ff  <= 1'b0;
         refSync_ff  <= 1'b0;
         hrstCnt_ff  <= 5'h00;
         enLow_ff    <= 1'b0;
         sleepReg_ff <= 1'b0;
      end else begin
         enMeta_ff   <= nxt_enMeta;
         enSync_ff   <= nxt_enSync;
         refMeta_ff  <= nxt_refMeta;
         refSync_ff  <= nxt_refSync;
         hrstCnt_ff  <= nxt_hrstCnt;
         enLow_ff    <= nxt_enLow;
         sleepReg_ff <= nxt_sleepReg;
      end
   end

   // Sleep regulator flop is outside intRst so it survives a hard reset
   assign intRst = srst | enLow_ff;
   assign regRst = intRst | softResetCmd;

   ////////////////////////////////////////////////////////////////////////////
   // Software registers
   logic [13:0] cellMask_ff, nxt_cellMask;
   logic [5:0]  testEn_ff, nxt_testEn;
   logic [13:0] tempLimit_ff, nxt_tempLimit;
   logic [1:0]  ctrl_ff, nxt_ctrl;
   logic [2:0]  irqMask_ff, nxt_irqMask;
   logic        wrMask, wrTestEn, wrLimit, wrCtrl, wrFault, wrIrq, wrIrqMask;

   assign wrMask    = regWrEn & (regAddr == `FQRC_ADDR_CELL_MASK);
   assign wrTestEn  = regWrEn & (regAddr == `FQRC_ADDR_TEST_EN);
   assign wrLimit   = regWrEn & (regAddr == `FQRC_ADDR_TEMP_LIMIT);
   assign wrCtrl    = regWrEn & (regAddr == `FQRC_ADDR_CTRL);
   assign wrFault   = regWrEn & (regAddr == `FQRC_ADDR_TEMP_FAULT);
   assign wrIrq     = regWrEn & (regAddr == `FQRC_ADDR_IRQ_STATUS);
   assign wrIrqMask = regWrEn & (regAddr == `FQRC_ADDR_IRQ_MASK);

   always_comb begin
      nxt_cellMask  = wrMask    ? regWrData[13:0] : cellMask_ff;
      nxt_testEn    = wrTestEn  ? regWrData[5:0]  : testEn_ff;
      nxt_tempLimit = wrLimit   ? regWrData[13:0] : tempLimit_ff;
      nxt_irqMask   = wrIrqMask ? regWrData[2:0]  : irqMask_ff;
      nxt_ctrl      = wrCtrl    ? regWrData[1:0]  : ctrl_ff;
      // Wake completion leaves sleep
      if (wakeDone) begin
         nxt_ctrl[`FQRC_CTRL_SLEEP] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (regRst) begin
         cellMask_ff  <= `FQRC_RST_CELL_MASK;
         testEn_ff    <= `FQRC_RST_TEST_EN;
         tempLimit_ff <= `FQRC_RST_TEMP_LIMIT;
         ctrl_ff      <= `FQRC_RST_CTRL;
         irqMask_ff   <= `FQRC_RST_IRQ_MASK;
      end else begin
         cellMask_ff  <= nxt_cellMask;
         testEn_ff    <= nxt_testEn;
         tempLimit_ff <= nxt_tempLimit;
         ctrl_ff      <= nxt_ctrl;
         irqMask_ff   <= nxt_irqMask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cell and temperature fault qualification
   logic [13:0] cellOpen_ff, nxt_cellOpen, cellUv_ff, nxt_cellUv;
   logic [5:0]  tempFault_ff, nxt_tempFault, tempSet;
   logic        faultSum_ff, nxt_faultSum;

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_temp
         logic hit;
         assign hit = tempIn.valid & (tempIn.idx == 3'(gi)) & testEn_ff[gi];
         // Open above 31/32 full scale, overheat below the limit
         assign tempSet[gi] = hit & ((tempIn.code > `FQRC_OPEN_THRESH) |
                                     (tempIn.code < tempLimit_ff));
      end
   endgenerate

   always_comb begin
      // Only reporting is gated; the measured voltage path is untouched
      nxt_cellOpen = cellIn.openRaw & ~cellMask_ff;
      nxt_cellUv   = cellIn.uvRaw & ~cellMask_ff;
      // Set wins over a same-cycle write-one clear
      nxt_tempFault = (tempFault_ff & ~(wrFault ? regWrData[5:0] : 6'h00)) | tempSet;
      nxt_faultSum  = |nxt_tempFault;
   end

   always_ff @(posedge sys_clk) begin
      if (regRst) begin
         cellOpen_ff  <= 14'h0000;
         cellUv_ff    <= 14'h0000;
         tempFault_ff <= 6'h00;
         faultSum_ff  <= 1'b0;
      end else begin
         cellOpen_ff  <= nxt_cellOpen;
         cellUv_ff    <= nxt_cellUv;
         tempFault_ff <= nxt_tempFault;
         faultSum_ff  <= nxt_faultSum;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference power-good check
   fqrc_pkg::fqrc_ref_e refState_ff, nxt_refState;
   logic [19:0] refCnt_ff, nxt_refCnt;
   logic        refFault_ff, nxt_refFault;
   logic        refFail;

   assign refFail = (refState_ff == fqrc_pkg::REF_CHECK) & ~refSync_ff;

   always_comb begin
      nxt_refState = refState_ff;
      nxt_refCnt   = refCnt_ff;
      nxt_refFault = refFault_ff | refFail;
      unique case (refState_ff)
         fqrc_pkg::REF_WAIT: begin
            if (refCnt_ff >= REF_DELAY_CYC - 20'h00001) begin
               nxt_refState = fqrc_pkg::REF_CHECK;
            end else begin
               nxt_refCnt = refCnt_ff + 20'h00001;
            end
         end
         fqrc_pkg::REF_CHECK: begin
            nxt_refState = fqrc_pkg::REF_CHECK;
         end
      endcase
      // Wake restarts the settling delay; reset release does the same
      if (wakeDone) begin
         nxt_refState = fqrc_pkg::REF_WAIT;
         nxt_refCnt   = 20'h00000;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (intRst) begin
         refState_ff <= fqrc_pkg::REF_WAIT;
         refCnt_ff   <= 20'h00000;
         refFault_ff <= 1'b0;
      end else begin
         refState_ff <= nxt_refState;
         refCnt_ff   <= nxt_refCnt;
         refFault_ff <= nxt_refFault;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts and read port
   logic [2:0]  irqStat_ff, nxt_irqStat, irqEvt;
   logic        intReq_ff, nxt_intReq;
   logic [15:0] rdData_ff, nxt_rdData;
   logic        passDrive_ff, nxt_passDrive;
   logic        bias_ff, nxt_bias;

   always_comb begin
      irqEvt = 3'h0;
      irqEvt[`FQRC_IRQ_TEMP] = |tempSet;
      irqEvt[`FQRC_IRQ_REF]  = refFail;
      irqEvt[`FQRC_IRQ_CELL] = |(nxt_cellOpen | nxt_cellUv);
      nxt_irqStat = (irqStat_ff & ~(wrIrq ? regWrData[2:0] : 3'h0)) | irqEvt;
      nxt_intReq  = |(nxt_irqStat & irqMask_ff);
      nxt_passDrive = ~ctrl_ff[`FQRC_CTRL_SLEEP];
      nxt_bias      = ctrl_ff[`FQRC_CTRL_BIAS];
      nxt_rdData = 16'h0000;
      if (regRdEn) begin
         unique case (regAddr)
            `FQRC_ADDR_CELL_MASK:  nxt_rdData = {2'h0, cellMask_ff};
            `FQRC_ADDR_TEST_EN:    nxt_rdData = {10'h000, testEn_ff};
            `FQRC_ADDR_TEMP_LIMIT: nxt_rdData = {2'h0, tempLimit_ff};
            `FQRC_ADDR_CTRL:       nxt_rdData = {14'h0000, ctrl_ff};
            `FQRC_ADDR_TEMP_FAULT: nxt_rdData = {10'h000, tempFault_ff};
            `FQRC_ADDR_IRQ_STATUS: nxt_rdData = {13'h0000, irqStat_ff};
            `FQRC_ADDR_IRQ_MASK:   nxt_rdData = {13'h0000, irqMask_ff};
            `FQRC_ADDR_STATUS: begin
               nxt_rdData[`FQRC_STAT_REF_ACTIVE] = refState_ff == fqrc_pkg::REF_CHECK;
               nxt_rdData[`FQRC_STAT_SLEEPING]   = ctrl_ff[`FQRC_CTRL_SLEEP];
               nxt_rdData[`FQRC_STAT_REF_FAULT]  = refFault_ff;
            end
            default:               nxt_rdData = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (regRst) begin
         irqStat_ff   <= 3'h0;
         intReq_ff    <= 1'b0;
         rdData_ff    <= 16'h0000;
         passDrive_ff <= 1'b1;
         bias_ff      <= 1'b0;
      end else begin
         irqStat_ff   <= nxt_irqStat;
         intReq_ff    <= nxt_intReq;
         rdData_ff    <= nxt_rdData;
         passDrive_ff <= nxt_passDrive;
         bias_ff      <= nxt_bias;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign regRdData            = rdData_ff;
   assign cellOpenFault        = cellOpen_ff;
   assign cellUvFault          = cellUv_ff;
   assign overTempFault        = tempFault_ff;
   assign overTempSummaryFlag  = faultSum_ff;
   assign refFault             = refFault_ff;
   assign passDriveOn          = passDrive_ff;
   assign sleepRegOn           = sleepReg_ff;
   assign tempBiasSwitchOutput = bias_ff;
   assign tempPullUpOn         = {6{bias_ff}};
   assign enLogicLow           = enLow_ff;
   assign intReq               = intReq_ff;

endmodule : fqrc_top

// ---- fqrc_consts.svh ----
`ifndef FQRC_CONSTS_SVH
`define FQRC_CONSTS_SVH
// Register word addresses
`define FQRC_ADDR_CELL_MASK   8'h00
`define FQRC_ADDR_TEST_EN     8'h01
`define FQRC_ADDR_TEMP_LIMIT  8'h02
`define FQRC_ADDR_CTRL        8'h03
`define FQRC_ADDR_TEMP_FAULT  8'h04
`define FQRC_ADDR_IRQ_STATUS  8'h05
`define FQRC_ADDR_IRQ_MASK    8'h06
`define FQRC_ADDR_STATUS      8'h07
// Field positions
`define FQRC_CTRL_BIAS        0
`define FQRC_CTRL_SLEEP       1
`define FQRC_IRQ_TEMP         0
`define FQRC_IRQ_REF          1
`define FQRC_IRQ_CELL         2
`define FQRC_STAT_REF_ACTIVE  0
`define FQRC_STAT_SLEEPING    1
`define FQRC_STAT_REF_FAULT   2
// Reset values
`define FQRC_RST_CELL_MASK    14'h0000
`define FQRC_RST_TEST_EN      6'h00
`define FQRC_RST_TEMP_LIMIT   14'h0000
`define FQRC_RST_CTRL         2'h0
`define FQRC_RST_IRQ_MASK     3'h0
// Thresholds and timing
`define FQRC_OPEN_THRESH      14'h3E00
`define FQRC_CLK_KHZ          40000
`define FQRC_REF_DELAY_MS     20
`define FQRC_REF_DELAY_CYC    (`FQRC_REF_DELAY_MS * `FQRC_CLK_KHZ)
`define FQRC_HRST_HOLD_CYC    5'h10
`endif

// ---- fqrc_pkg.sv ----
package fqrc_pkg;
   // Cell fault inputs from the measurement logic
   typedef struct packed {
      logic [13:0] openRaw;
      logic [13:0] uvRaw;
   } fqrc_cell_s;
   // One temperature conversion result
   typedef struct packed {
      logic        valid;
      logic [2:0]  idx;
      logic [13:0] code;
   } fqrc_temp_s;
   typedef enum logic [1:0] {
      REF_WAIT  = 2'b00,
      REF_CHECK = 2'b01
   } fqrc_ref_e;
endpackage : fqrc_pkg

// ---- fqrc_top_sva.sv ----
module fqrc_top_sva (
   // Clock and reset
   input wire logic                 sys_clk,
   input wire logic                 srst,
   // Watched ports
   input wire logic                 enPin,
   input wire logic                 hardResetCmd,
   input wire logic                 softResetCmd,
   input wire logic                 regWrEn,
   input wire fqrc_pkg::fqrc_cell_s cellIn,
   input wire logic [13:0]          cellOpenFault,
   input wire logic [5:0]           overTempFault,
   input wire logic                 overTempSummaryFlag,
   input wire logic                 refFault,
   input wire logic                 sleepRegOn,
   input wire logic                 tempBiasSwitchOutput,
   input wire logic [5:0]           tempPullUpOn,
   input wire logic                 enLogicLow,
   input wire logic                 intReq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   // Sync chain needs three edges; one spare
   sequence enHeldLow;
      !enPin [*4];
   endsequence
   sequence resetHold;
      enLogicLow [*8];
   endsequence
   ////////////////////////////////////////////////////////////////////////
   AST_MASK_OPEN: assert property (
      (cellOpenFault & ~$past(cellIn.openRaw)) == 14'h0000)
      else $error("Open fault without raw fault");
   AST_SUMMARY: assert property (
      overTempSummaryFlag == |overTempFault)
      else $error("Summary flag disagrees with fault bits");
   AST_TEMP_STICKY: assert property (
      !regWrEn && !softResetCmd && !enLogicLow |=>
      (overTempFault & $past(overTempFault)) == $past(overTempFault))
      else $error("Fault bit dropped on its own");
   AST_PULLUP: assert property (
      tempPullUpOn == {6{tempBiasSwitchOutput}})
      else $error("Pull-ups not following bias output");
   AST_HARD_HOLD: assert property (hardResetCmd |=> resetHold)
      else $error("Hard reset not held");
   AST_EN_LOW: assert property (enHeldLow |=> enLogicLow)
      else $error("Enable low did not reset");
   AST_RESET_CLR: assert property (
      enLogicLow |=> overTempFault == 6'h00 && !refFault && !intReq
      && cellOpenFault == 14'h0000)
      else $error("State survived internal reset");
   AST_SLEEP_REG: assert property (enLogicLow |-> sleepRegOn)
      else $error("Sleep regulator dropped in reset");
endmodule : fqrc_top_sva

bind fqrc_top fqrc_top_sva chk_u (
   .sys_clk(sys_clk), .srst(srst), .enPin(enPin), .hardResetCmd(hardResetCmd),
   .softResetCmd(softResetCmd), .regWrEn(regWrEn), .cellIn(cellIn),
   .cellOpenFault(cellOpenFault), .overTempFault(overTempFault),
   .overTempSummaryFlag(overTempSummaryFlag), .refFault(refFault),
   .sleepRegOn(sleepRegOn), .tempBiasSwitchOutput(tempBiasSwitchOutput),
   .tempPullUpOn(tempPullUpOn), .enLogicLow(enLogicLow), .intReq(intReq)
);

// ---- fqrc_reset_host.sv ----
module fqrc_reset_host (
   // Clock
   input  wire logic sys_clk,
   // Requests from the bench
   input  wire logic pullEnLow,
   input  wire logic sendHard,
   input  wire logic sendSoft,
   // Towards the device
   output logic      enPin,
   output logic      hardResetCmd,
   output logic      softResetCmd
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pull-up wins whenever the driver lets go
   assign enPin = !pullEnLow;
   // Link commands arrive as one-cycle pulses
   always_ff @(posedge sys_clk) begin
      hardResetCmd <= sendHard;
      softResetCmd <= sendSoft;
   end
endmodule : fqrc_reset_host

// ---- fqrc_tb_top.sv ----
`include "fqrc_consts.svh"
module fqrc_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, srst, regWrEn, regRdEn, refGoodPin, wakeDone, overTempSummaryFlag;
   logic pullEnLow, sendHard, sendSoft, enPin, hardResetCmd, softResetCmd, refFault;
   logic passDriveOn, sleepRegOn, tempBiasSwitchOutput, enLogicLow, intReq;
   logic [7:0]           regAddr;
   logic [15:0]          regWrData, regRdData, rdVal;
   logic [13:0]          cellOpenFault, cellUvFault;
   logic [5:0]           overTempFault, tempPullUpOn;
   fqrc_pkg::fqrc_cell_s cellIn;
   fqrc_pkg::fqrc_temp_s tempIn;
   int                   miscompares, n_compared, cycles = 0;
   // Short delay keeps the power-good wait visible in a short run
   fqrc_top #(.REF_DELAY_CYC(20'h00014)) dut_u (.sys_clk(sys_clk), .srst(srst),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .enPin(enPin), .refGoodPin(refGoodPin),
      .hardResetCmd(hardResetCmd), .softResetCmd(softResetCmd), .wakeDone(wakeDone),
      .cellIn(cellIn), .tempIn(tempIn), .cellOpenFault(cellOpenFault),
      .cellUvFault(cellUvFault), .overTempFault(overTempFault),
      .overTempSummaryFlag(overTempSummaryFlag), .refFault(refFault),
      .passDriveOn(passDriveOn), .sleepRegOn(sleepRegOn), .tempPullUpOn(tempPullUpOn),
      .tempBiasSwitchOutput(tempBiasSwitchOutput), .enLogicLow(enLogicLow),
      .intReq(intReq));
   fqrc_reset_host host_u (.sys_clk(sys_clk), .pullEnLow(pullEnLow), .sendHard(sendHard),
      .sendSoft(sendSoft), .enPin(enPin), .hardResetCmd(hardResetCmd),
      .softResetCmd(softResetCmd));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Strobe drops one edge before the next call may raise it
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      #1;
      rdVal = regRdData;
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic send(input logic [2:0] i, input logic [13:0] c);
      @(posedge sys_clk);
      tempIn <= '{valid: 1'b1, idx: i, code: c};
      @(posedge sys_clk);
      tempIn.valid <= 1'b0;
   endtask : send
   ////////////////////////////////////////////////////////////////////////
   task automatic t_defaults;
      rd(`FQRC_ADDR_CELL_MASK);
      chk(rdVal, 16'h0000);
      wr(8'h20, 16'hFFFF);
      rd(8'h20);
      chk(rdVal, 16'h0000);
      chk(sleepRegOn, 16'h0001);
   endtask : t_defaults
   task automatic t_mask;
      logic [15:0] m [4] = '{16'h0210, 16'h0001, 16'h2000, 16'hFFFF};
      foreach (m[i]) begin
         wr(`FQRC_ADDR_CELL_MASK, m[i]);
         rd(`FQRC_ADDR_CELL_MASK);
         chk(rdVal, m[i] & 16'h3FFF);
         cellIn <= '{openRaw: 14'h3FFF, uvRaw: 14'h2AAA};
         cyc(3);
         chk(cellOpenFault, 14'(~m[i]));
         chk(cellUvFault, 14'h2AAA & 14'(~m[i]));
      end
      cellIn <= '0;
   endtask : t_mask
   task automatic t_temp;
      wr(`FQRC_ADDR_TEST_EN, 16'h003D);
      wr(`FQRC_ADDR_TEMP_LIMIT, 16'h0800);
      send(3'h0, 14'h3E01);
      send(3'h2, 14'h3E00);
      send(3'h3, 14'h07FF);
      send(3'h1, 14'h3FFF);
      send(3'h4, 14'h0800);
      cyc(2);
      chk(overTempFault, 16'h0009);
      chk(overTempSummaryFlag, 16'h0001);
      chk(intReq, 16'h0000);
      wr(`FQRC_ADDR_IRQ_MASK, 16'h0001);
      cyc(2);
      chk(intReq, 16'h0001);
      wr(`FQRC_ADDR_IRQ_STATUS, 16'h0001);
      cyc(2);
      chk(intReq, 16'h0000);
      wr(`FQRC_ADDR_TEMP_FAULT, 16'h0001);
      rd(`FQRC_ADDR_TEMP_FAULT);
      chk(rdVal, 16'h0008);
      wr(`FQRC_ADDR_TEMP_FAULT, 16'h0008);
      cyc(1);
      chk(overTempSummaryFlag, 16'h0000);
   endtask : t_temp
   task automatic t_power;
      wr(`FQRC_ADDR_CTRL, 16'h0001);
      cyc(2);
      chk(tempPullUpOn, 16'h003F);
      chk(tempBiasSwitchOutput, 16'h0001);
      wr(`FQRC_ADDR_CTRL, 16'h0002);
      cyc(2);
      chk(tempPullUpOn, 16'h0000);
      chk(tempBiasSwitchOutput, 16'h0000);
      chk(passDriveOn, 16'h0000);
      @(posedge sys_clk);
      wakeDone <= 1'b1;
      @(posedge sys_clk);
      wakeDone <= 1'b0;
      cyc(2);
      chk(passDriveOn, 16'h0001);
   endtask : t_power
   task automatic t_hard;
      int n;
      wr(`FQRC_ADDR_CELL_MASK, 16'h1234);
      refGoodPin <= 1'b0;
      sendHard <= 1'b1;
      @(posedge sys_clk);
      sendHard <= 1'b0;
      cyc(2);
      chk(enLogicLow, 16'h0001);
      chk(sleepRegOn, 16'h0001);
      // Poll a settled value, not the flop at its launching edge
      for (n = 0; n < 40 && enLogicLow; n++) cyc(1);
      chk(16'(n), 16'(`FQRC_HRST_HOLD_CYC - 5'h01));
      cyc(10);
      chk(refFault, 16'h0000);
      cyc(30);
      chk(refFault, 16'h0001);
      refGoodPin <= 1'b1;
      // Check active, not sleeping, fault latched
      rd(`FQRC_ADDR_STATUS);
      chk(rdVal, 16'h0005);
      rd(`FQRC_ADDR_CELL_MASK);
      chk(rdVal, 16'h0000);
   endtask : t_hard
   task automatic t_soft;
      wr(`FQRC_ADDR_CELL_MASK, 16'h1234);
      sendSoft <= 1'b1;
      @(posedge sys_clk);
      sendSoft <= 1'b0;
      cyc(3);
      rd(`FQRC_ADDR_CELL_MASK);
      chk(rdVal, 16'h0000);
   endtask : t_soft
   task automatic t_en;
      wr(`FQRC_ADDR_CELL_MASK, 16'h0FF0);
      pullEnLow <= 1'b1;
      cyc(6);
      chk(enLogicLow, 16'h0001);
      chk(refFault, 16'h0000);
      pullEnLow <= 1'b0;
      cyc(6);
      rd(`FQRC_ADDR_CELL_MASK);
      chk(rdVal, 16'h0000);
   endtask : t_en
   ////////////////////////////////////////////////////////////////////////
   // Whole run is under two hundred cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         give_verdict;
      end
   end
   initial begin
      srst = 1'b1;
      {regWrEn, regRdEn, wakeDone, pullEnLow, sendHard, sendSoft} = 6'h00;
      refGoodPin = 1'b1;
      regAddr = 8'h00;
      regWrData = 16'h0000;
      cellIn = '0;
      tempIn = '0;
      miscompares = 0;
      n_compared = 0;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      t_defaults;
      t_mask;
      t_temp;
      t_power;
      t_hard;
      t_soft;
      t_en;
      give_verdict;
   end
endmodule : fqrc_tb_top
